//--- common/uart_b_params.svh
// offsets, field positions, reset values and timing counts of channel b
// assumes a 32-bit AXI4-Lite slave with one aligned word per register
`ifndef UART_B_PARAMS_SVH
`define UART_B_PARAMS_SVH

// register byte offsets
`define OFS_MODEM_CTRL 8'h00
`define OFS_FEATURE_CTRL 8'h04
`define OFS_ENH_FEATURE 8'h08
`define OFS_EXT_MODE 8'h0c
`define OFS_INT_ENABLE 8'h10
`define OFS_INT_STATUS 8'h14
`define OFS_INT_CLEAR 8'h18
`define OFS_PIN_STATUS 8'h1c
`define OFS_TX_DATA 8'h20

// field positions
`define MCR_DTR 0
`define MCR_RTS 1
`define MCR_OP2 3
`define MCR_IR 6
`define MCR_PRESC 7
`define FEATURE_CONTROL_REG_IR_INV 2
`define FEATURE_CONTROL_REG_AUTO_DIR 3
`define EFR_AUTO_RTS 6
`define EFR_AUTO_CTS 7
`define EXTENDED_MODE_SELECT_REG_DIR_POL 3
`define INT_TX_DONE 0
`define INT_DSR 4
`define INT_RI 5
`define INT_CD 6
`define INT_CTS 7

// reset values
`define RST_REG8 8'h00

// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// timing counts
`define PRESCALE_LAST 2'd3
`define SAMPLE_LAST 4'd15
`define IR_PULSE_SAMPLES 4'd3
`define FRAME_BITS 4'd10

`endif

//--- common/uart_b_pkg.sv
// state types shared by the channel b control block and its helpers
// assumes the constants of uart_b_params.svh
`default_nettype none

package uart_b_pkg;

    typedef struct packed {
        logic [1:0] pre;
        logic [15:0] cnt;
        logic tick;
    } presc_state_t;

    typedef struct packed {
        logic [9:0] shift;
        logic [3:0] nbits;
        logic [3:0] sub;
        logic busy;
        logic done;
    } tx_state_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_strb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] modem_control_reg;
        logic [7:0] feature_control_reg;
        logic [7:0] enhanced_feature_reg;
        logic [7:0] extended_mode_select_reg;
        logic [7:0] interrupt_enable_reg;
        logic [7:0] ists;
        logic sw_presc;
        logic pin_cap_done;
        logic pin_div4;
        logic [7:0] hold_data;
        logic hold_valid;
        logic [3:0] pin_q;
        logic rx_level;
        logic serial_out;
        logic rts_n;
        logic dtr_n;
        logic op2_n;
        logic irq;
        logic irq_oe_n;
    } top_state_t;

endpackage

`default_nettype wire

//--- hdl/baud_prescaler.sv
// sample-rate enable: clock divided by 1 or 4, then by a divisor
// assumes div4 and divisor are steady while a character is sent
`default_nettype none
`include "uart_b_params.svh"

module baud_prescaler (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic div4,
    input wire logic [15:0] divisor,
    output logic tick
);
    import uart_b_pkg::*;

    presc_state_t s;
    presc_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (div4 && s.pre != `PRESCALE_LAST) begin
            next_s.pre = s.pre + 2'd1;
        end else begin
            next_s.pre = 2'd0;
            if (s.cnt >= divisor - 16'd1) begin
                next_s.cnt = 16'd0;
                next_s.tick = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 16'd1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

endmodule

`default_nettype wire

//--- hdl/tx_shifter.sv
// one start bit, eight data bits lsb first, one stop bit
// assumes tick is a one-cycle enable at sixteen samples per bit
`default_nettype none
`include "uart_b_params.svh"

module tx_shifter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic start,
    input wire logic [7:0] data,
    output logic busy,
    output logic done,
    output logic line,
    output logic first_part
);
    import uart_b_pkg::*;

    tx_state_t s;
    tx_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        if (!s.busy) begin
            if (start) begin
                next_s.busy = 1'b1;
                next_s.shift = {1'b1, data, 1'b0};
                next_s.nbits = `FRAME_BITS;
                next_s.sub = 4'd0;
            end
        end else if (tick) begin
            if (s.sub == `SAMPLE_LAST) begin
                next_s.sub = 4'd0;
                next_s.shift = {1'b1, s.shift[9:1]};
                next_s.nbits = s.nbits - 4'd1;
                if (s.nbits == 4'd1) begin
                    next_s.busy = 1'b0;
                    next_s.done = 1'b1;
                end
            end else begin
                next_s.sub = s.sub + 4'd1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '{shift: 10'h3ff, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign busy = s.busy;
    assign done = s.done;
    assign line = s.shift[0];
    // infrared pulse occupies the first samples of a zero bit
    assign first_part = s.sub < `IR_PULSE_SAMPLES;

endmodule

`default_nettype wire

//--- hdl/uart_modem_pin_and_config_control.sv
// channel b serial, modem and configuration pins behind AXI4-Lite
// assumes pins synchronous to aclk; one write and one read in flight
// Functional notes
// - standard mode: transmit idles and resets high
// - infrared mode: encoded path, transmit idles low
// - software bit inverts infrared receive input
// - automatic half-duplex direction on send request
// - direction to receive after stop, back on load
// - clear-to-send gates transmit, optional interrupt
// - set-ready, carrier, ring: status only, optional interrupt
// - output port bit one: pin low, irq driven
// - output port bit zero: pin high, irq released
// - bus-select pin only read back, in pin status bit seven
// - prescaler pin sampled only at reset
// - prescaler pin high divides 1, low 4
// - software prescaler bit overrides latched pin
// - sleep input makes host bus ignored
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`default_nettype none
`include "uart_b_params.svh"

module uart_modem_pin_and_config_control #(
    parameter logic [15:0] BAUD_DIV = 16'd1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic chan_b_serial_out,
    input wire logic chan_b_serial_in,
    output logic chan_b_request_send_n,
    input wire logic chan_b_clear_send_n,
    output logic chan_b_terminal_ready_n,
    input wire logic chan_b_set_ready_n,
    input wire logic chan_b_carrier_detect_n,
    input wire logic chan_b_ring_indicator_n,
    output logic chan_b_output_port_n,
    output logic chan_b_irq_out,
    output logic chan_b_irq_oe_n,
    input wire logic bus_isolate_sleep,
    input wire logic host_bus_strobe_sel,
    input wire logic baud_prescale_sel
);
    import uart_b_pkg::*;

    top_state_t s;
    top_state_t next_s;
    logic tick;
    logic div4;
    logic tx_start;
    logic tx_busy;
    logic tx_done;
    logic tx_line;
    logic tx_first;
    logic tx_active;
    logic [3:0] pins;
    logic [7:0] pin_stat;
    logic [7:0] events;

    // ------------------------------------------------------------
    // baud path
    // ------------------------------------------------------------
    // software override
    assign div4 = s.sw_presc ? s.modem_control_reg[`MCR_PRESC] : s.pin_div4;

    baud_prescaler u_presc (
        .aclk(aclk),
        .aresetn(aresetn),
        .div4(div4),
        .divisor(BAUD_DIV),
        .tick(tick)
    );

    assign tx_start = s.hold_valid && !tx_busy &&
        !(s.enhanced_feature_reg[`EFR_AUTO_CTS] && chan_b_clear_send_n);

    tx_shifter u_tx (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .start(tx_start),
        .data(s.hold_data),
        .busy(tx_busy),
        .done(tx_done),
        .line(tx_line),
        .first_part(tx_first)
    );

    // transmit state while a byte is loaded
    assign tx_active = s.hold_valid || tx_busy || tx_start;

    // ------------------------------------------------------------
    // status words
    // ------------------------------------------------------------
    // modem inputs watched, clear-to-send also gates transmit
    assign pins = {chan_b_ring_indicator_n, chan_b_carrier_detect_n,
        chan_b_set_ready_n, chan_b_clear_send_n};
    assign pin_stat = {host_bus_strobe_sel, div4, tx_active, s.rx_level,
        s.pin_q};
    assign events = {pins[0] != s.pin_q[0], pins[2] != s.pin_q[2],
        pins[3] != s.pin_q[3], pins[1] != s.pin_q[1], 3'b000, tx_done};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.pin_q = pins;
        if (!s.pin_cap_done) begin
            next_s.pin_cap_done = 1'b1;
            // low pin means divide by four
            next_s.pin_div4 = !baud_prescale_sel;
        end
        if (tx_start) begin
            next_s.hold_valid = 1'b0;
        end

        if (awvalid && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.w_data = wdata[7:0];
            next_s.w_strb0 = wstrb[0];
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (next_s.aw_got && next_s.w_got && !next_s.bvalid) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = `RESP_OKAY;
            if (!bus_isolate_sleep && next_s.w_strb0) begin
                case (next_s.aw_addr)
                    `OFS_MODEM_CTRL: begin
                        next_s.modem_control_reg = next_s.w_data;
                        next_s.sw_presc = 1'b1;
                    end
                    `OFS_FEATURE_CTRL: next_s.feature_control_reg = next_s.w_data;
                    `OFS_ENH_FEATURE: next_s.enhanced_feature_reg = next_s.w_data;
                    `OFS_EXT_MODE: next_s.extended_mode_select_reg = next_s.w_data;
                    `OFS_INT_ENABLE: next_s.interrupt_enable_reg = next_s.w_data;
                    `OFS_INT_CLEAR: next_s.ists = s.ists & ~next_s.w_data;
                    `OFS_TX_DATA: begin
                        // a byte written while one waits is dropped
                        if (!s.hold_valid) begin
                            next_s.hold_data = next_s.w_data;
                            next_s.hold_valid = 1'b1;
                        end
                    end
                    `OFS_INT_STATUS, `OFS_PIN_STATUS: begin
                    end
                    default: next_s.bresp = `RESP_SLVERR;
                endcase
            end else if (next_s.aw_addr > `OFS_TX_DATA ||
                next_s.aw_addr[1:0] != 2'b00) begin
                next_s.bresp = `RESP_SLVERR;
            end
        end
        // set wins over a clear in the same cycle
        next_s.ists = next_s.ists | events;
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready = !next_s.w_got && !next_s.bvalid;

        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = `RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            case (araddr)
                `OFS_MODEM_CTRL: next_s.rdata[7:0] = s.modem_control_reg;
                `OFS_FEATURE_CTRL: next_s.rdata[7:0] = s.feature_control_reg;
                `OFS_ENH_FEATURE: next_s.rdata[7:0] = s.enhanced_feature_reg;
                `OFS_EXT_MODE: next_s.rdata[7:0] = s.extended_mode_select_reg;
                `OFS_INT_ENABLE: next_s.rdata[7:0] = s.interrupt_enable_reg;
                `OFS_INT_STATUS: next_s.rdata[7:0] = s.ists;
                `OFS_PIN_STATUS: next_s.rdata[7:0] = pin_stat;
                `OFS_INT_CLEAR, `OFS_TX_DATA: begin
                end
                default: next_s.rresp = `RESP_SLVERR;
            endcase
            if (bus_isolate_sleep) begin
                next_s.rdata = 32'h0000_0000;
            end
        end
        next_s.arready = !next_s.rvalid;

        if (s.modem_control_reg[`MCR_IR]) begin
            next_s.rx_level = !(chan_b_serial_in ^ s.feature_control_reg[`FEATURE_CONTROL_REG_IR_INV]);
        end else begin
            next_s.rx_level = chan_b_serial_in;
        end

        if (s.modem_control_reg[`MCR_IR]) begin
            // pulse per zero bit, idles low
            next_s.serial_out = tx_busy && !tx_line && tx_first;
        end else begin
            next_s.serial_out = !tx_busy || tx_line;
        end

        if (s.feature_control_reg[`FEATURE_CONTROL_REG_AUTO_DIR]) begin
            next_s.rts_n = !tx_active ^ s.extended_mode_select_reg[`EXTENDED_MODE_SELECT_REG_DIR_POL];
        end else begin
            // plain request bit drives the pin
            next_s.rts_n = !s.modem_control_reg[`MCR_RTS];
        end
        next_s.dtr_n = !s.modem_control_reg[`MCR_DTR];
        next_s.op2_n = !s.modem_control_reg[`MCR_OP2];
        next_s.irq_oe_n = !s.modem_control_reg[`MCR_OP2];
        next_s.irq = |(s.ists & s.interrupt_enable_reg);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                pin_q: 4'hf, serial_out: 1'b1, rts_n: 1'b1, dtr_n: 1'b1,
                op2_n: 1'b1, irq_oe_n: 1'b1, rx_level: 1'b1,
                default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign chan_b_serial_out = s.serial_out;
    assign chan_b_request_send_n = s.rts_n;
    assign chan_b_terminal_ready_n = s.dtr_n;
    assign chan_b_output_port_n = s.op2_n;
    assign chan_b_irq_out = s.irq;
    assign chan_b_irq_oe_n = s.irq_oe_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence frame_end;
        tx_done && !s.hold_valid && !tx_start;
    endsequence

    std_idle_high_a: assert property (
        !s.modem_control_reg[`MCR_IR] && !tx_busy |=> chan_b_serial_out)
        else $error("standard line not idle high");
    ir_idle_low_a: assert property (
        s.modem_control_reg[`MCR_IR] && !tx_busy |=> !chan_b_serial_out)
        else $error("infrared line not idle low");
    ir_rx_invert_a: assert property (
        s.modem_control_reg[`MCR_IR] |=> s.rx_level ==
        !($past(chan_b_serial_in) ^ $past(s.feature_control_reg[`FEATURE_CONTROL_REG_IR_INV])))
        else $error("infrared receive polarity wrong");
    dir_tx_state_a: assert property (
        s.feature_control_reg[`FEATURE_CONTROL_REG_AUTO_DIR] && tx_busy |=>
        chan_b_request_send_n == $past(s.extended_mode_select_reg[`EXTENDED_MODE_SELECT_REG_DIR_POL]))
        else $error("direction pin not in transmit state");
    dir_release_a: assert property (
        s.feature_control_reg[`FEATURE_CONTROL_REG_AUTO_DIR] and frame_end |=>
        chan_b_request_send_n != $past(s.extended_mode_select_reg[`EXTENDED_MODE_SELECT_REG_DIR_POL]))
        else $error("direction pin not released after stop");
    cts_hold_a: assert property (
        s.enhanced_feature_reg[`EFR_AUTO_CTS] && chan_b_clear_send_n |-> !tx_start)
        else $error("transmit started against clear-to-send");
    cts_irq_a: assert property (
        chan_b_clear_send_n != s.pin_q[0] && s.interrupt_enable_reg[`INT_CTS]
        |=> s.ists[`INT_CTS] ##1 chan_b_irq_out)
        else $error("clear-to-send change raised no interrupt");
    port_on_a: assert property (
        s.modem_control_reg[`MCR_OP2] |=> !chan_b_output_port_n && !chan_b_irq_oe_n)
        else $error("output port bit one not honoured");
    port_off_a: assert property (
        !s.modem_control_reg[`MCR_OP2] |=> chan_b_output_port_n && chan_b_irq_oe_n)
        else $error("output port bit zero not honoured");
    presc_frozen_a: assert property (
        s.pin_cap_done |=> $stable(s.pin_div4))
        else $error("prescaler pin resampled");
    presc_override_a: assert property (
        s.sw_presc |-> div4 == s.modem_control_reg[`MCR_PRESC])
        else $error("software prescaler bit ignored");
    sleep_isolate_a: assert property (
        bus_isolate_sleep |=> $stable(s.modem_control_reg) && $stable(s.interrupt_enable_reg))
        else $error("register written while isolated");
    dtr_follow_a: assert property (
        s.modem_control_reg[`MCR_DTR] ##1 s.modem_control_reg[`MCR_DTR] |-> !chan_b_terminal_ready_n)
        else $error("terminal ready not following bit");

endmodule

`default_nettype wire

//--- tb/serial_line_model.sv
// line transceiver model facing the channel b serial pins
// assumes one serial bit lasts BIT_CLKS cycles of aclk while listening
`default_nettype none

module serial_line_model #(
    parameter int BIT_CLKS = 16
) (
    input wire logic aclk,
    input wire logic line,
    input wire logic listen,
    input wire logic ir_inv,
    output logic rx_out,
    output logic [7:0] byte_seen,
    output logic stop_seen,
    output int count
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // receive line driver
    // ----------------------------------------
    // idle receive levels
    assign rx_out = listen | ir_inv;

    // ----------------------------------------
    // frame decoder, samples mid bit
    // ----------------------------------------
    initial begin
        byte_seen = 8'h00;
        stop_seen = 1'b0;
        count = 0;
        forever begin
            @(negedge line iff listen);
            repeat (BIT_CLKS / 2) @(posedge aclk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CLKS) @(posedge aclk);
                byte_seen[i] = line;
            end
            repeat (BIT_CLKS) @(posedge aclk);
            stop_seen = line;
            count++;
        end
    end

endmodule

`default_nettype wire

//--- tb/tb_uart_modem_pin_and_config_control.sv
// self-checking bench for the channel b pin and configuration block
// assumes the design files and serial_line_model are compiled first
`default_nettype none
`include "uart_b_params.svh"

module tb_uart_modem_pin_and_config_control;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic ser_out, ser_in, rts_n, cts_n, dtr_n, dsr_n, cd_n, ri_n;
    logic op2_n, irq, irq_oe_n, sleep, host_sel, presc_sel;
    logic std_mode, ir_inv, stop_bit;
    logic [7:0] rx_byte;
    int rx_count, num_errors, checks;

    uart_modem_pin_and_config_control #(.BAUD_DIV(16'd1))
    i_uart_modem_pin_and_config_control (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .chan_b_serial_out(ser_out), .chan_b_serial_in(ser_in),
        .chan_b_request_send_n(rts_n), .chan_b_clear_send_n(cts_n),
        .chan_b_terminal_ready_n(dtr_n), .chan_b_set_ready_n(dsr_n),
        .chan_b_carrier_detect_n(cd_n),
        .chan_b_ring_indicator_n(ri_n), .chan_b_output_port_n(op2_n),
        .chan_b_irq_out(irq), .chan_b_irq_oe_n(irq_oe_n),
        .bus_isolate_sleep(sleep), .host_bus_strobe_sel(host_sel),
        .baud_prescale_sel(presc_sel)
    );

    serial_line_model #(.BIT_CLKS(16)) i_serial_line_model (
        .aclk(aclk), .line(ser_out), .listen(std_mode),
        .ir_inv(ir_inv), .rx_out(ser_in), .byte_seen(rx_byte),
        .stop_seen(stop_bit), .count(rx_count)
    );

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic stall;
        num_errors++;
        end_sim();
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    // both channels offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bit done;
        done = 0;
        r = 2'b11;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 64 && !done; n++) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                done = 1;
            end
        end
        if (!done) stall();
    endtask

    task automatic rd(input logic [7:0] a);
        bit done;
        done = 0;
        r = 2'b11;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 64 && !done; n++) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1;
            end
        end
        if (!done) stall();
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(d, exp);
    endtask

    task automatic wait_rx(input int n);
        for (int k = 0; k < 4000 && rx_count < n; k++) @(posedge aclk);
        if (rx_count < n) stall();
        #1;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'h0;
        {cts_n, dsr_n, cd_n, ri_n} = 4'hf;
        {sleep, host_sel, presc_sel, std_mode, ir_inv} = 5'h0e;
        d = 32'h0;
        num_errors = 0;
        checks = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        idle(2);
        chk({ser_out, rts_n, dtr_n, irq}, 32'he);
        chk({op2_n, irq_oe_n}, 32'h3);
        rdchk(`OFS_MODEM_CTRL, 32'h0);
        rdchk(`OFS_INT_STATUS, 32'h0);
        $display("test reset done");

        rdchk(`OFS_PIN_STATUS, 32'h9f);
        host_sel <= 1'b0;
        presc_sel <= 1'b0;
        rdchk(`OFS_PIN_STATUS, 32'h1f);
        wr(`OFS_MODEM_CTRL, 32'h80);
        rdchk(`OFS_PIN_STATUS, 32'h5f);
        wr(`OFS_MODEM_CTRL, 32'h00);
        rdchk(`OFS_PIN_STATUS, 32'h1f);
        $display("test prescaler done");

        wr(`OFS_MODEM_CTRL, 32'h0b);
        wr(`OFS_ENH_FEATURE, 32'h40);
        idle(3);
        chk({rts_n, dtr_n, op2_n, irq_oe_n}, 32'h0);
        wr(`OFS_MODEM_CTRL, 32'h00);
        wr(`OFS_ENH_FEATURE, 32'h00);
        idle(3);
        chk({rts_n, dtr_n, op2_n, irq_oe_n}, 32'hf);
        $display("test modem outputs done");

        // pins move only on a rising edge
        @(posedge aclk);
        {dsr_n, cd_n, ri_n} <= 3'b000;
        wr(`OFS_TX_DATA, 32'ha5);
        wait_rx(1);
        chk({stop_bit, rx_byte}, 32'h1a5);
        idle(20);
        chk(ser_out, 32'h1);
        @(posedge aclk);
        {dsr_n, cd_n, ri_n} <= 3'b111;
        rdchk(`OFS_INT_STATUS, 32'h71);
        chk(irq, 32'h0);
        wr(`OFS_INT_CLEAR, 32'hff);
        rdchk(`OFS_INT_STATUS, 32'h0);
        $display("test transmit done");

        wr(`OFS_INT_ENABLE, 32'h80);
        wr(`OFS_ENH_FEATURE, 32'h80);
        wr(`OFS_TX_DATA, 32'h3c);
        idle(64);
        chk({rx_count[7:0], ser_out}, 32'h3);
        @(posedge aclk);
        cts_n <= 1'b0;
        idle(4);
        chk(irq, 32'h1);
        wait_rx(2);
        chk(rx_byte, 32'h3c);
        wr(`OFS_INT_CLEAR, 32'h80);
        idle(3);
        chk(irq, 32'h0);
        wr(`OFS_ENH_FEATURE, 32'h00);
        cts_n <= 1'b1;
        wr(`OFS_INT_ENABLE, 32'h00);
        wr(`OFS_INT_CLEAR, 32'hff);
        $display("test clear to send done");

        wr(`OFS_FEATURE_CTRL, 32'h08);
        idle(3);
        chk(rts_n, 32'h1);
        wr(`OFS_TX_DATA, 32'h81);
        idle(4);
        chk(rts_n, 32'h0);
        wait_rx(3);
        idle(20);
        chk({rts_n, rx_byte}, 32'h181);
        wr(`OFS_EXT_MODE, 32'h08);
        idle(3);
        chk(rts_n, 32'h0);
        wr(`OFS_FEATURE_CTRL, 32'h00);
        wr(`OFS_EXT_MODE, 32'h00);
        $display("test direction done");

        std_mode <= 1'b0;
        wr(`OFS_MODEM_CTRL, 32'h40);
        idle(3);
        chk(ser_out, 32'h0);
        rdchk(`OFS_PIN_STATUS, 32'h1f);
        ir_inv <= 1'b1;
        wr(`OFS_FEATURE_CTRL, 32'h04);
        rdchk(`OFS_PIN_STATUS, 32'h1f);
        // an all-ones byte leaves one pulse, for its start bit
        wr(`OFS_TX_DATA, 32'hff);
        idle(2);
        chk(ser_out, 32'h1);
        idle(3);
        chk(ser_out, 32'h0);
        idle(160);
        wr(`OFS_FEATURE_CTRL, 32'h00);
        ir_inv <= 1'b0;
        wr(`OFS_MODEM_CTRL, 32'h00);
        std_mode <= 1'b1;
        $display("test infrared done");

        wr(8'h24, 32'h1);
        chk(r, `RESP_SLVERR);
        rdchk(8'h24, 32'h0);
        chk(r, `RESP_SLVERR);
        sleep <= 1'b1;
        wr(`OFS_MODEM_CTRL, 32'h01);
        chk(r, `RESP_OKAY);
        sleep <= 1'b0;
        rdchk(`OFS_MODEM_CTRL, 32'h0);
        chk(dtr_n, 32'h1);
        $display("test bus refusals done");
        end_sim();
    end

endmodule

`default_nettype wire
